// >>> design/bnc_top.sv
// Purpose: Settings and status registers of the building network port
// Assumes: Register master and message detector share SYS_CLK
// Notes:   Effective values are registered one cycle after a change
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "bnc_cfg.svh"

// Summary of operation
// - Protocol code 0 disabled, 1 Modbus RTU, 2 BACnet, 3 vendor.
// - Protocol codes above 3 disable the network.
// - Rate codes 1 to 8 give 1200 through 76800 bits per second.
// - Rate code 0 or above 8 uses the protocol default rate.
// - Address ranges: Modbus 1-247, BACnet 0-127, vendor 1-255.
// - Out-of-range address uses that protocol's maximum address.
// - Count every valid message received under the active protocol.
// - Counter wraps to zero after 9999 and clears at reset.
// - BACnet polls next master up to the max master setting.
// - Max master writes above 127 store and use 127.
// - Firmware version split into main and patch read-only values.
// - Fixed read-only identification code readable like settings.
// - BACnet zero object id uses node address, or 1 if zero.
module bnc_top #(
	parameter logic [15:0] ID_CODE  = 16'h0123, // Arbitrary value
	parameter logic [15:0] FW_MAIN  = 16'h0065, // Arbitrary value
	parameter logic [15:0] FW_PATCH = 16'h0000  // Arbitrary value
) (
	// Clock, reset, enable
	input  wire logic                   SYS_CLK,
	input  wire logic                   RST_B,
	input  wire logic                   CLK_EN,
	// Register port
	input  wire logic [`BNC_ADDR_W-1:0] REG_ADDR,
	input  wire logic [`BNC_DATA_W-1:0] REG_WDATA,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	output logic      [`BNC_DATA_W-1:0] REG_RDATA,
	// Receiver status
	input  wire logic                   MSG_VALID,
	// Effective settings
	output logic                        NET_ENABLE,
	output logic      [1:0]             PROTO_EFF,
	output logic      [`BNC_RATE_W-1:0] LINE_RATE_BPS,
	output logic      [`BNC_DATA_W-1:0] NODE_ADDR_EFF,
	output logic      [`BNC_DATA_W-1:0] POLL_MAX_ADDR,
	output logic      [`BNC_DATA_W-1:0] DEV_OBJ_ID
);

	bnc_cfg_if cfg ();

	bnc_resolve u_resolve (
		.cfg (cfg.resolver)
	);

	// Stored settings
	logic [`BNC_DATA_W-1:0] node_q,  node_d;
	logic [`BNC_DATA_W-1:0] rate_q,  rate_d;
	logic [`BNC_DATA_W-1:0] proto_q, proto_d;
	logic [`BNC_DATA_W-1:0] mast_q,  mast_d;
	logic [`BNC_DATA_W-1:0] obj_q,   obj_d;
	// Status and read path
	logic [`BNC_DATA_W-1:0] cnt_q,   cnt_d;
	logic [`BNC_DATA_W-1:0] rdata_q, rdata_d;
	// Registered effective values
	logic                   en_q,    en_d;
	logic [1:0]             pro_q,   pro_d;
	logic [`BNC_RATE_W-1:0] bps_q,   bps_d;
	logic [`BNC_DATA_W-1:0] addr_q,  addr_d;
	logic [`BNC_DATA_W-1:0] poll_q,  poll_d;
	logic [`BNC_DATA_W-1:0] oid_q,   oid_d;

	logic wr_node, wr_rate, wr_proto, wr_mast, wr_obj;

	assign cfg.proto_raw = proto_q;
	assign cfg.rate_raw  = rate_q;
	assign cfg.node_raw  = node_q;
	assign cfg.max_mast  = mast_q;
	assign cfg.obj_raw   = obj_q;

	// Writes to read-only or unmapped indexes are dropped silently
	assign wr_node  = REG_WR && REG_ADDR == `BNC_IDX_NODE;
	assign wr_rate  = REG_WR && REG_ADDR == `BNC_IDX_RATE;
	assign wr_proto = REG_WR && REG_ADDR == `BNC_IDX_PROTO;
	assign wr_mast  = REG_WR && REG_ADDR == `BNC_IDX_MAX_MAST;
	assign wr_obj   = REG_WR && REG_ADDR == `BNC_IDX_OBJ_ID;

	// Setting storage
	always_comb begin
		node_d  = wr_node  ? REG_WDATA : node_q;
		rate_d  = wr_rate  ? REG_WDATA : rate_q;
		proto_d = wr_proto ? REG_WDATA : proto_q;
		obj_d   = wr_obj   ? REG_WDATA : obj_q;
		mast_d  = mast_q;
		if (wr_mast) begin
			// Clamp at store time so readback shows the value in use
			mast_d = (REG_WDATA > `BNC_MAX_MAST_TOP) ?
				`BNC_MAX_MAST_TOP : REG_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			node_q  <= `BNC_RST_NODE;
			rate_q  <= `BNC_RST_RATE;
			proto_q <= `BNC_RST_PROTO;
			mast_q  <= `BNC_RST_MAX_MAST;
			obj_q   <= `BNC_RST_OBJ_ID;
		end else if (CLK_EN) begin
			node_q  <= node_d;
			rate_q  <= rate_d;
			proto_q <= proto_d;
			mast_q  <= mast_d;
			obj_q   <= obj_d;
		end
	end

	// Message counter, only counts while a protocol is active
	always_comb begin
		cnt_d = cnt_q;
		if (MSG_VALID && cfg.proto != bnc_pkg::BNC_OFF) begin
			cnt_d = (cnt_q >= `BNC_MSG_CNT_TOP) ?
				16'h0000 : cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			cnt_q <= 16'h0000;
		end else if (CLK_EN) begin
			cnt_q <= cnt_d;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		rdata_d = 16'h0000;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`BNC_IDX_ID:       rdata_d = ID_CODE;
				`BNC_IDX_FW_MAIN:  rdata_d = FW_MAIN;
				`BNC_IDX_FW_PATCH: rdata_d = FW_PATCH;
				`BNC_IDX_NODE:     rdata_d = node_q;
				`BNC_IDX_RATE:     rdata_d = rate_q;
				`BNC_IDX_PROTO:    rdata_d = proto_q;
				`BNC_IDX_MSG_CNT:  rdata_d = cnt_q;
				`BNC_IDX_MAX_MAST: rdata_d = mast_q;
				`BNC_IDX_OBJ_ID:   rdata_d = obj_q;
				default:           rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rdata_q <= 16'h0000;
		end else if (CLK_EN) begin
			rdata_q <= rdata_d;
		end
	end

	// Effective values, recomputed from settings every cycle
	always_comb begin
		en_d   = cfg.proto != bnc_pkg::BNC_OFF;
		pro_d  = cfg.proto;
		bps_d  = cfg.rate_bps;
		addr_d = cfg.node_eff;
		poll_d = cfg.poll_max;
		oid_d  = cfg.obj_eff;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			en_q   <= 1'b0;
			pro_q  <= 2'h0;
			bps_q  <= `BNC_BPS_NONE;
			addr_q <= 16'h0000;
			poll_q <= 16'h0000;
			oid_q  <= 16'h0000;
		end else if (CLK_EN) begin
			en_q   <= en_d;
			pro_q  <= pro_d;
			bps_q  <= bps_d;
			addr_q <= addr_d;
			poll_q <= poll_d;
			oid_q  <= oid_d;
		end
	end

	assign REG_RDATA     = rdata_q;
	assign NET_ENABLE    = en_q;
	assign PROTO_EFF     = pro_q;
	assign LINE_RATE_BPS = bps_q;
	assign NODE_ADDR_EFF = addr_q;
	assign POLL_MAX_ADDR = poll_q;
	assign DEV_OBJ_ID    = oid_q;

endmodule // bnc_top

// >>> design/bnc_cfg.svh
// Purpose: Constants for the building network configuration block
// Assumes: 16-bit register data, word index addressing
// Notes:   Offsets are register indexes on the plain register port
`ifndef BNC_CFG_SVH
`define BNC_CFG_SVH

`define BNC_ADDR_W        4
`define BNC_DATA_W        16

`define BNC_IDX_ID        4'h0
`define BNC_IDX_FW_MAIN   4'h1
`define BNC_IDX_FW_PATCH  4'h2
`define BNC_IDX_NODE      4'h3
`define BNC_IDX_RATE      4'h4
`define BNC_IDX_PROTO     4'h5
`define BNC_IDX_MSG_CNT   4'h6
`define BNC_IDX_MAX_MAST  4'h7
`define BNC_IDX_OBJ_ID    4'h8

`define BNC_RST_NODE      16'h0000
`define BNC_RST_RATE      16'h0000
`define BNC_RST_PROTO     16'h0000
`define BNC_RST_MAX_MAST  16'h007f
`define BNC_RST_OBJ_ID    16'h0000

`define BNC_PROTO_MAX     16'h0003
`define BNC_RATE_CODE_MAX 16'h0008
`define BNC_MSG_CNT_TOP   16'h270f
`define BNC_MAX_MAST_TOP  16'h007f

`define BNC_MB_ADDR_MIN   16'h0001
`define BNC_MB_ADDR_MAX   16'h00f7
`define BNC_BN_ADDR_MIN   16'h0000
`define BNC_BN_ADDR_MAX   16'h007f
`define BNC_V3_ADDR_MIN   16'h0001
`define BNC_V3_ADDR_MAX   16'h00ff

`define BNC_RATE_W        17
`define BNC_BPS_1200      17'h004b0
`define BNC_BPS_2400      17'h00960
`define BNC_BPS_4800      17'h012c0
`define BNC_BPS_9600      17'h02580
`define BNC_BPS_19200     17'h04b00
`define BNC_BPS_38400     17'h09600
`define BNC_BPS_57600     17'h0e100
`define BNC_BPS_76800     17'h12c00
`define BNC_BPS_3000      17'h00bb8
`define BNC_BPS_NONE      17'h00000

`endif

// >>> design/bnc_pkg.sv
// Purpose: Types for the building network configuration block
// Assumes: Constants live in bnc_cfg.svh
// Notes:   Protocol order matches the select codes 0..3
package bnc_pkg;

	typedef enum logic [1:0] {
		BNC_OFF,
		BNC_MODBUS,
		BNC_BACNET,
		BNC_VENDOR
	} bnc_proto_t;

endpackage

// >>> design/bnc_cfg_if.sv
// Purpose: Carries stored settings to the resolver and results back
// Assumes: Single clock domain, purely combinational path
// Notes:   Owner drives settings, resolver drives effective values
`timescale 1ns/100ps
`include "bnc_cfg.svh"

interface bnc_cfg_if;
	logic [`BNC_DATA_W-1:0] proto_raw;
	logic [`BNC_DATA_W-1:0] rate_raw;
	logic [`BNC_DATA_W-1:0] node_raw;
	logic [`BNC_DATA_W-1:0] max_mast;
	logic [`BNC_DATA_W-1:0] obj_raw;
	bnc_pkg::bnc_proto_t    proto;
	logic [`BNC_RATE_W-1:0] rate_bps;
	logic [`BNC_DATA_W-1:0] node_eff;
	logic [`BNC_DATA_W-1:0] poll_max;
	logic [`BNC_DATA_W-1:0] obj_eff;

	modport owner (
		output proto_raw, rate_raw, node_raw, max_mast, obj_raw,
		input  proto, rate_bps, node_eff, poll_max, obj_eff
	);
	modport resolver (
		input  proto_raw, rate_raw, node_raw, max_mast, obj_raw,
		output proto, rate_bps, node_eff, poll_max, obj_eff
	);
endinterface // bnc_cfg_if

// >>> design/bnc_resolve.sv
// Purpose: Derives effective protocol, rate, address and identifiers
// Assumes: Stored settings are stable values from the owner
// Notes:   Pure combinational; the owner registers the results
`timescale 1ns/100ps
`include "bnc_cfg.svh"

module bnc_resolve (
	// Settings in, effective values out
	bnc_cfg_if.resolver cfg
);

	// Default rate for a protocol, used for codes 0 and above 8
	function automatic logic [`BNC_RATE_W-1:0] dflt_rate(
		input bnc_pkg::bnc_proto_t p);
		unique case (p)
			bnc_pkg::BNC_OFF:    dflt_rate = `BNC_BPS_NONE;
			bnc_pkg::BNC_MODBUS: dflt_rate = `BNC_BPS_19200;
			bnc_pkg::BNC_BACNET: dflt_rate = `BNC_BPS_9600;
			bnc_pkg::BNC_VENDOR: dflt_rate = `BNC_BPS_3000;
		endcase
	endfunction

	// Clamp to range, out of range takes the maximum
	function automatic logic [`BNC_DATA_W-1:0] clamp_addr(
		input logic [`BNC_DATA_W-1:0] a,
		input logic [`BNC_DATA_W-1:0] lo,
		input logic [`BNC_DATA_W-1:0] hi);
		clamp_addr = (a < lo || a > hi) ? hi : a;
	endfunction

	always_comb begin
		// Values above 3 mean disabled
		if (cfg.proto_raw > `BNC_PROTO_MAX) begin
			cfg.proto = bnc_pkg::BNC_OFF;
		end else begin
			cfg.proto = bnc_pkg::bnc_proto_t'(cfg.proto_raw[1:0]);
		end
	end

	always_comb begin
		unique case (cfg.rate_raw)
			16'h0001: cfg.rate_bps = `BNC_BPS_1200;
			16'h0002: cfg.rate_bps = `BNC_BPS_2400;
			16'h0003: cfg.rate_bps = `BNC_BPS_4800;
			16'h0004: cfg.rate_bps = `BNC_BPS_9600;
			16'h0005: cfg.rate_bps = `BNC_BPS_19200;
			16'h0006: cfg.rate_bps = `BNC_BPS_38400;
			16'h0007: cfg.rate_bps = `BNC_BPS_57600;
			16'h0008: cfg.rate_bps = `BNC_BPS_76800;
			default:  cfg.rate_bps = dflt_rate(cfg.proto);
		endcase
	end

	always_comb begin
		unique case (cfg.proto)
			bnc_pkg::BNC_OFF: cfg.node_eff = 16'h0000;
			bnc_pkg::BNC_MODBUS: cfg.node_eff = clamp_addr(cfg.node_raw,
				`BNC_MB_ADDR_MIN, `BNC_MB_ADDR_MAX);
			bnc_pkg::BNC_BACNET: cfg.node_eff = clamp_addr(cfg.node_raw,
				`BNC_BN_ADDR_MIN, `BNC_BN_ADDR_MAX);
			bnc_pkg::BNC_VENDOR: cfg.node_eff = clamp_addr(cfg.node_raw,
				`BNC_V3_ADDR_MIN, `BNC_V3_ADDR_MAX);
		endcase
	end

	always_comb begin
		// Polling limit and object id only mean anything under BACnet
		cfg.poll_max = 16'h0000;
		cfg.obj_eff  = cfg.obj_raw;
		if (cfg.proto == bnc_pkg::BNC_BACNET) begin
			cfg.poll_max = cfg.max_mast;
			if (cfg.obj_raw == 16'h0000) begin
				cfg.obj_eff = (cfg.node_eff == 16'h0000) ?
					16'h0001 : cfg.node_eff;
			end
		end
	end

endmodule // bnc_resolve

// >>> tb/bnc_top_chk.sv
// Purpose: Port-level assertions for bnc_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Storage is hidden, so checks tie outputs to each other
`timescale 1ns/100ps
module bnc_top_chk (
	// Clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic        CLK_EN,
	// Register port
	input wire logic [3:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_RDATA,
	// Message and effective values
	input wire logic        MSG_VALID,
	input wire logic        NET_ENABLE,
	input wire logic [1:0]  PROTO_EFF,
	input wire logic [16:0] LINE_RATE_BPS,
	input wire logic [15:0] NODE_ADDR_EFF,
	input wire logic [15:0] POLL_MAX_ADDR,
	input wire logic [15:0] DEV_OBJ_ID
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	property p_en; NET_ENABLE == (PROTO_EFF != 2'h0); endproperty
	a_en: assert property (p_en) else $error("enable mismatch");
	property p_off; PROTO_EFF == 2'h0 |-> LINE_RATE_BPS == 17'h0
		&& NODE_ADDR_EFF == 16'h0 && POLL_MAX_ADDR == 16'h0; endproperty
	a_off: assert property (p_off) else $error("off not quiet");
	property p_rate; PROTO_EFF != 2'h0 |-> LINE_RATE_BPS inside {17'h4b0,
		17'h960, 17'h12c0, 17'h2580, 17'h4b00, 17'h9600, 17'he100,
		17'h12c00, 17'hbb8}; endproperty
	a_rate: assert property (p_rate) else $error("bad rate");
	property p_mb;
		PROTO_EFF == 2'h1 |-> NODE_ADDR_EFF inside {[16'h1:16'hf7]};
	endproperty
	a_mb: assert property (p_mb) else $error("modbus addr");
	property p_bn; PROTO_EFF == 2'h2 |-> NODE_ADDR_EFF <= 16'h7f
		&& POLL_MAX_ADDR <= 16'h7f; endproperty
	a_bn: assert property (p_bn) else $error("bacnet range");
	property p_v3;
		PROTO_EFF == 2'h3 |-> NODE_ADDR_EFF inside {[16'h1:16'hff]};
	endproperty
	a_v3: assert property (p_v3) else $error("vendor addr");
	property p_obj; PROTO_EFF == 2'h2 |-> DEV_OBJ_ID != 16'h0; endproperty
	a_obj: assert property (p_obj) else $error("object id zero");
	// Gap cycle keeps a later small write from spoiling the readback
	sequence s_clamp;
		CLK_EN && REG_WR && REG_ADDR == 4'h7 && REG_WDATA > 16'h7f ##1
		!REG_WR ##1 CLK_EN && REG_RD && REG_ADDR == 4'h7;
	endsequence
	property p_clamp; s_clamp |=> REG_RDATA == 16'h7f; endproperty
	a_clamp: assert property (p_clamp) else $error("no clamp");
	c_clamp: cover property (s_clamp);
	c_obj1: cover property (PROTO_EFF == 2'h2 && DEV_OBJ_ID == 16'h1);
	c_v3: cover property (PROTO_EFF == 2'h3 && NODE_ADDR_EFF == 16'hff);
endmodule // bnc_top_chk

bind bnc_top bnc_top_chk bnc_top_chk_inst (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
	.CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.MSG_VALID(MSG_VALID), .NET_ENABLE(NET_ENABLE), .PROTO_EFF(PROTO_EFF),
	.LINE_RATE_BPS(LINE_RATE_BPS), .NODE_ADDR_EFF(NODE_ADDR_EFF),
	.POLL_MAX_ADDR(POLL_MAX_ADDR), .DEV_OBJ_ID(DEV_OBJ_ID));

// >>> tb/bnc_msg_src.sv
// Purpose: Stand-in for the receiver's valid message detector
// Assumes: Shares the system clock with the block
// Notes:   Pulses may run back to back, one message per cycle
`timescale 1ns/100ps
module bnc_msg_src (
	// Clock
	input wire logic clk,
	// Message pulse
	output logic     msg_valid
);
	initial msg_valid = 1'b0;
	task automatic send(input int n);
		repeat (n) begin
			@(posedge clk);
			msg_valid <= 1'b1;
		end
		@(posedge clk);
		msg_valid <= 1'b0;
	endtask
endmodule // bnc_msg_src

// >>> tb/bnc_top_tb_top.sv
// Purpose: Self-checking bench for bnc_top
// Assumes: Default identity parameters, clock enable mostly high
// Notes:   Outputs are sampled 1 ns after the edge that updates them
`timescale 1ns/100ps
module bnc_top_tb_top;
	logic        sys_clk, rst_b, reg_wr, reg_rd, msg_valid, net_enable;
	logic        clk_en;
	logic [3:0]  reg_addr;
	logic [1:0]  proto_eff;
	logic [15:0] reg_wdata, reg_rdata, node_eff, poll_max, obj_id, rd_q;
	logic [16:0] rate_bps;
	int          err_total, tests_run;

	bnc_top bnc_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
		.CLK_EN(clk_en), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.MSG_VALID(msg_valid),
		.NET_ENABLE(net_enable), .PROTO_EFF(proto_eff),
		.LINE_RATE_BPS(rate_bps), .NODE_ADDR_EFF(node_eff),
		.POLL_MAX_ADDR(poll_max), .DEV_OBJ_ID(obj_id));
	bnc_msg_src bnc_msg_src_inst (.clk(sys_clk), .msg_valid(msg_valid));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask
	// Effective outputs lag storage by one edge
	task automatic settle();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic t_regs();
		logic [15:0] e [10] = '{16'h123, 16'h65, 16'h0, 16'h0, 16'h0,
			16'h0, 16'h0, 16'h7f, 16'h0, 16'h0};
		for (int i = 0; i < 10; i++) begin
			rd(4'(i));
			chk({1'b0, rd_q}, {1'b0, e[i]});
		end
		wr(4'h0, 16'h5555);
		rd(4'h0);
		chk({1'b0, rd_q}, 17'h123);
		// Read data must drop back to zero after its one cycle
		settle();
		chk({1'b0, reg_rdata}, 17'h0);
		$display("t_regs done");
	endtask
	task automatic t_proto();
		for (int p = 0; p < 6; p++) begin
			wr(4'h5, 16'(p));
			settle();
			chk({15'h0, proto_eff}, (p > 3) ? 17'h0 : 17'(p));
			chk({16'h0, net_enable}, 17'(p > 0 && p < 4));
		end
		$display("t_proto done");
	endtask
	task automatic t_rate();
		logic [16:0] b [10] = '{17'h4b00, 17'h4b0, 17'h960, 17'h12c0,
			17'h2580, 17'h4b00, 17'h9600, 17'he100, 17'h12c00, 17'h4b00};
		wr(4'h5, 16'h1);
		for (int i = 0; i < 10; i++) begin
			wr(4'h4, 16'(i));
			settle();
			chk(rate_bps, b[i]);
		end
		wr(4'h5, 16'h2);
		settle();
		chk(rate_bps, 17'h2580);
		wr(4'h5, 16'h3);
		settle();
		chk(rate_bps, 17'hbb8);
		$display("t_rate done");
	endtask
	task automatic t_addr();
		// Packed as protocol, written address, expected address
		logic [31:0] t [8] = '{32'h100000f7, 32'h10010001, 32'h10f700f7,
			32'h10f800f7, 32'h20000000, 32'h2080007f, 32'h300000ff,
			32'h310000ff};
		for (int i = 0; i < 8; i++) begin
			wr(4'h5, {12'h0, t[i][31:28]});
			wr(4'h3, {4'h0, t[i][27:16]});
			settle();
			chk({1'b0, node_eff}, {1'b0, t[i][15:0]});
			rd(4'h3);
			chk({1'b0, rd_q}, {5'h0, t[i][27:16]});
		end
		$display("t_addr done");
	endtask
	task automatic t_bac();
		wr(4'h5, 16'h2);
		// Start low so the clamp visibly moves the polling limit
		wr(4'h7, 16'h5);
		settle();
		chk({1'b0, poll_max}, 17'h5);
		wr(4'h7, 16'hc8);
		rd(4'h7);
		chk({1'b0, rd_q}, 17'h7f);
		chk({1'b0, poll_max}, 17'h7f);
		wr(4'h3, 16'h0);
		wr(4'h8, 16'h0);
		settle();
		chk({1'b0, obj_id}, 17'h1);
		wr(4'h3, 16'h5);
		settle();
		chk({1'b0, obj_id}, 17'h5);
		wr(4'h8, 16'h9);
		settle();
		chk({1'b0, obj_id}, 17'h9);
		wr(4'h5, 16'h1);
		settle();
		chk({1'b0, poll_max}, 17'h0);
		$display("t_bac done");
	endtask
	task automatic t_cnt();
		wr(4'h5, 16'h7);
		bnc_msg_src_inst.send(3);
		rd(4'h6);
		chk({1'b0, rd_q}, 17'h0);
		wr(4'h5, 16'h3);
		bnc_msg_src_inst.send(9999);
		rd(4'h6);
		chk({1'b0, rd_q}, 17'h270f);
		bnc_msg_src_inst.send(1);
		rd(4'h6);
		chk({1'b0, rd_q}, 17'h0);
		$display("t_cnt done");
	endtask
	// Enable low must swallow a write; then a mid-run reset
	task automatic t_hold();
		wr(4'h5, 16'h1);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= 4'h5;
		reg_wdata <= 16'h2;
		@(posedge sys_clk);
		clk_en <= 1'b1;
		reg_wr <= 1'b0;
		settle();
		chk({15'h0, proto_eff}, 17'h1);
		bnc_msg_src_inst.send(2);
		rd(4'h6);
		chk({1'b0, rd_q}, 17'h2);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		@(posedge sys_clk);
		rst_b <= 1'b1;
		rd(4'h6);
		chk({1'b0, rd_q}, 17'h0);
		rd(4'h7);
		chk({1'b0, rd_q}, 17'h7f);
		chk({15'h0, proto_eff}, 17'h0);
		$display("t_hold done");
	endtask
	task automatic final_report();
		$display("Compared %0d, mismatched %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		clk_en = 1'b1;
		err_total = 0;
		tests_run = 0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_proto();
		t_rate();
		t_addr();
		t_bac();
		t_cnt();
		t_hold();
		final_report();
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		err_total++;
		final_report();
	end
endmodule // bnc_top_tb_top
